//--- hw/gisa_pkg.sv
// constants shared by the global interrupt and status aggregator
package gisa_pkg;

  // ************************************************************
  // register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] IDX_GLOBAL_INTERRUPT_SUMMARY        = 8'h10;
  localparam logic [7:0] IDX_GLOBAL_INTERRUPT_SUMMARY_ENABLE = 8'h12;
  localparam logic [7:0] IDX_GLOBAL_LIVE_STATUS              = 8'h14;
  localparam logic [7:0] IDX_GLOBAL_LATCHED_STATUS           = 8'h16;
  localparam logic [7:0] IDX_GLOBAL_STATUS_INTERRUPT_ENABLE  = 8'h18;
  localparam logic [7:0] IDX_GENERAL_PIN_READBACK            = 8'h1c;
  localparam logic [7:0] IDX_GLOBAL_CONTROL                  = 8'h20;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int POS_GLOBAL_SUMMARY   = 0;  // summary / summary enable
  localparam int POS_TX_SYSIF_SUMMARY = 1;
  localparam int POS_PORT_SUMMARY     = 4;  // bits 7 to 4
  localparam int POS_PERF_DONE        = 0;  // live, latched, enable
  localparam int POS_PLL_UNLOCK       = 1;
  localparam int POS_ONE_SECOND       = 2;
  localparam int POS_CLOCK_REF        = 3;
  localparam int POS_REF8K            = 4;
  localparam int POS_PIN1_SELECT      = 0;  // control, bits 1 to 0
  localparam int POS_CLEAR_ON_READ    = 2;
  localparam int POS_UPDATE_REQUEST   = 3;
  localparam int POS_IDLE_MODE        = 4;
  localparam int POS_REF8K_SELECT     = 5;
  localparam int POS_PORT_UPD_SELECT  = 8;  // control, bits 11 to 8

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0]  RST_SUMMARY_ENABLE = 8'h00;
  localparam logic [2:0]  RST_STATUS_ENABLE  = 3'h0;
  localparam logic [4:0]  RST_LATCHED        = 5'h00;
  localparam logic [11:0] RST_CONTROL        = 12'h000;

  // ************************************************************
  // pin 1 function codes
  // ************************************************************
  localparam logic [1:0] PIN1_INPUT    = 2'h0;
  localparam logic [1:0] PIN1_STATUS_A = 2'h1;
  localparam logic [1:0] PIN1_LOW      = 2'h2;
  localparam logic [1:0] PIN1_HIGH     = 2'h3;

endpackage

//--- hw/edge_watch.sv
// one-cycle pulse on a change of a synchronous level
`timescale 1ns/1ps
`default_nettype none

module edge_watch #(
  parameter bit RISE_ONLY = 1'b1  // 1: low-to-high only, 0: any change
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic enable_i,     // gates the watch; off means no pulse
  input  wire logic level_i,
  output logic      pulse_o
);

  logic prev;  // level seen one edge earlier

  // ************************************************************
  // history of the watched level
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev <= 1'b0;
    end else begin
      prev <= level_i;
    end
  end

  // combinational so the owner can latch in the same edge it registers
  assign pulse_o = enable_i & (RISE_ONLY ? (level_i & ~prev) : (level_i ^ prev));

endmodule

`default_nettype wire

//--- hw/global_interrupt_status_aggregator.sv
// global interrupt and status aggregator with a classic wishbone slave
`timescale 1ns/1ps
`default_nettype none

// How it works
// - pin 1 select: input, status A, low, high
// - port summary bit follows any port status
// - enabled port summary pulls interrupt low
// - tx summary set by enabled latched tx bits
// - enabled tx summary pulls interrupt low
// - global summary set by enabled latched bits
// - enabled global summary pulls interrupt low
// - live unlock high while any pll unlocked
// - live update done is AND of selected ports while the update request is high
// - 8 kHz activity latched only when selected
// - clock reference activity latched on activity
// - one second tick latched, feeds global summary
// - unlock latched on live rising edge
// - update done latched on live rising edge
// - global source interrupts need both the source enable and the global summary enable
// - readback shows levels of eight pins
// - interrupt low when active, else high or released
// - latched clear by write or by read
module global_interrupt_status_aggregator #(
  parameter int PORTS  = 4,  // line ports feeding summaries
  parameter int PLLS   = 3,  // plls in the clock adapter
  parameter int ADDR_W = 8   // wishbone byte address width
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // classic wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // status sources
  input  wire logic [PORTS-1:0]  port_isr_any_i,        // any port status bit set
  input  wire logic [1:0]        tx_sysif_latched_i,    // latched tx interface bits
  input  wire logic [1:0]        tx_sysif_irq_enable_i, // their interrupt enables
  input  wire logic [PLLS-1:0]   pll_locked_i,
  input  wire logic [PORTS-1:0]  port_update_done_i,
  input  wire logic              one_second_tick_i,     // one-cycle pulse per second
  input  wire logic              clock_ref_input_pin_i,
  input  wire logic              port_status_select_a_i, // port 1 status A
  // general purpose pins, pin 1 is bidirectional
  input  wire logic [7:0]        gpio_i,
  output logic                   gpio1_o,
  output logic                   gpio1_oe_n_o,
  // interrupt pin, active low
  output logic                   int_n_o,
  output logic                   int_oe_n_o,
  // update request towards the ports
  output logic                   global_update_request_o,
  output logic [PORTS-1:0]       port_global_update_select_o
);

  // ************************************************************
  // storage
  // ************************************************************
  logic [7:0]  summary_enable;  // port [7:4], tx [1], global [0]
  logic [2:0]  status_enable;   // one second, unlock, update done
  logic [4:0]  latched;         // global latched status group
  logic [11:0] control;         // own control bits
  logic        pll_unlock_live;
  logic        perf_update_done_live;
  logic [PORTS-1:0] port_summary_flags;

  // ************************************************************
  // bus decode
  // ************************************************************
  logic        req;        // access taken at this edge
  logic        wr_lo;      // write touching bits 7 to 0
  logic        wr_hi;      // write touching bits 15 to 8
  logic [31:0] next_dat;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = ADDR_W'({idx, 2'b00});
  endfunction

  // true when the bus points at the given register
  function automatic logic hit(input logic [7:0] idx);
    hit = (adr_i == byte_addr(idx));
  endfunction

  assign req   = cyc_i & stb_i & ~ack_o;
  assign wr_lo = req & we_i & sel_i[0];
  assign wr_hi = req & we_i & sel_i[1];

  // control field views
  logic [1:0]       pin1_function_select;
  logic             latched_clear_on_read_enable;
  logic             interrupt_pin_idle_mode;
  logic             ref8k_input_select;
  assign pin1_function_select         = control[gisa_pkg::POS_PIN1_SELECT +: 2];
  assign latched_clear_on_read_enable = control[gisa_pkg::POS_CLEAR_ON_READ];
  assign interrupt_pin_idle_mode      = control[gisa_pkg::POS_IDLE_MODE];
  assign ref8k_input_select           = control[gisa_pkg::POS_REF8K_SELECT];

  // ************************************************************
  // ack: one cycle after the request, dropped the cycle after
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // ************************************************************
  // writable registers
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      summary_enable <= gisa_pkg::RST_SUMMARY_ENABLE;
      status_enable  <= gisa_pkg::RST_STATUS_ENABLE;
      control        <= gisa_pkg::RST_CONTROL;
    end else begin
      // enables live in the low byte only
      if (wr_lo && hit(gisa_pkg::IDX_GLOBAL_INTERRUPT_SUMMARY_ENABLE)) begin
        summary_enable <= dat_i[7:0] & 8'hf3;
      end
      if (wr_lo && hit(gisa_pkg::IDX_GLOBAL_STATUS_INTERRUPT_ENABLE)) begin
        status_enable <= dat_i[2:0];
      end
      if (wr_lo && hit(gisa_pkg::IDX_GLOBAL_CONTROL)) begin
        control[7:0] <= dat_i[7:0] & 8'h3f;
      end
      if (wr_hi && hit(gisa_pkg::IDX_GLOBAL_CONTROL)) begin
        control[11:8] <= dat_i[11:8];
      end
    end
  end

  // ************************************************************
  // live status
  // ************************************************************
  logic [PORTS-1:0] port_upd_select;
  assign port_upd_select = control[gisa_pkg::POS_PORT_UPD_SELECT +: PORTS];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_unlock_live       <= 1'b0;
      perf_update_done_live <= 1'b0;
      port_summary_flags    <= '0;
    end else begin
      pll_unlock_live       <= ~&pll_locked_i;
      // reads low while the request is low; the host keeps it up until done
      perf_update_done_live <= control[gisa_pkg::POS_UPDATE_REQUEST]
                               & (&(port_update_done_i | ~port_upd_select));
      port_summary_flags    <= port_isr_any_i;
    end
  end

  // ************************************************************
  // event pulses for the latched group
  // ************************************************************
  logic unlock_rise;
  logic perf_rise;
  logic ref8k_act;
  logic clkref_act;

  edge_watch #(.RISE_ONLY(1'b1)) u_unlock (
    .clk_i(clk_i), .rst_i(rst_i), .enable_i(1'b1), .level_i(pll_unlock_live), .pulse_o(unlock_rise));
  edge_watch #(.RISE_ONLY(1'b1)) u_perf (
    .clk_i(clk_i), .rst_i(rst_i), .enable_i(1'b1), .level_i(perf_update_done_live), .pulse_o(perf_rise));
  // activity means a transition was seen; a stuck reference never sets it
  edge_watch #(.RISE_ONLY(1'b0)) u_ref8k (
    .clk_i(clk_i), .rst_i(rst_i), .enable_i(ref8k_input_select), .level_i(gpio_i[3]), .pulse_o(ref8k_act));
  edge_watch #(.RISE_ONLY(1'b0)) u_clkref (
    .clk_i(clk_i), .rst_i(rst_i), .enable_i(1'b1), .level_i(clock_ref_input_pin_i), .pulse_o(clkref_act));

  logic [4:0] set_vec;
  logic [4:0] clr_vec;
  assign set_vec = {ref8k_act, clkref_act, one_second_tick_i, unlock_rise, perf_rise};

  // clear source picked by the clear-on-read bit
  always_comb begin
    clr_vec = 5'h00;
    if (req && hit(gisa_pkg::IDX_GLOBAL_LATCHED_STATUS)) begin
      if (latched_clear_on_read_enable && !we_i) begin
        clr_vec = 5'h1f;
      end else if (!latched_clear_on_read_enable && we_i && sel_i[0]) begin
        clr_vec = dat_i[4:0];
      end
    end
  end

  // ************************************************************
  // latched group: set wins over a clear in the same cycle
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latched <= gisa_pkg::RST_LATCHED;
    end else begin
      latched <= set_vec | (latched & ~clr_vec);
    end
  end

  // ************************************************************
  // summaries and the interrupt decision
  // ************************************************************
  logic       global_summary_flag;
  logic       tx_sysif_summary_flag;
  logic [7:0] summary;
  logic       irq_any;
  assign global_summary_flag   = |(latched[2:0] & status_enable);
  assign tx_sysif_summary_flag = |(tx_sysif_latched_i & tx_sysif_irq_enable_i);
  assign summary = {4'(port_summary_flags), 2'b00, tx_sysif_summary_flag, global_summary_flag};
  assign irq_any = |(summary[7:4] & summary_enable[7:4])
                 | (tx_sysif_summary_flag & summary_enable[gisa_pkg::POS_TX_SYSIF_SUMMARY])
                 | (global_summary_flag & summary_enable[gisa_pkg::POS_GLOBAL_SUMMARY]);

  // ************************************************************
  // pin drivers, all registered
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_n_o      <= 1'b1;
      int_oe_n_o   <= 1'b1;
      gpio1_o      <= 1'b0;
      gpio1_oe_n_o <= 1'b1;
    end else begin
      int_n_o    <= ~irq_any;
      int_oe_n_o <= ~(irq_any | interrupt_pin_idle_mode);
      unique case (pin1_function_select)
        gisa_pkg::PIN1_INPUT: begin
          gpio1_o      <= 1'b0;
          gpio1_oe_n_o <= 1'b1;
        end
        gisa_pkg::PIN1_STATUS_A: begin
          gpio1_o      <= port_status_select_a_i;
          gpio1_oe_n_o <= 1'b0;
        end
        gisa_pkg::PIN1_LOW: begin
          gpio1_o      <= 1'b0;
          gpio1_oe_n_o <= 1'b0;
        end
        gisa_pkg::PIN1_HIGH: begin
          gpio1_o      <= 1'b1;
          gpio1_oe_n_o <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // update request outputs
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_update_request_o     <= 1'b0;
      port_global_update_select_o <= '0;
    end else begin
      global_update_request_o     <= control[gisa_pkg::POS_UPDATE_REQUEST];
      port_global_update_select_o <= port_upd_select;
    end
  end

  // ************************************************************
  // read mux, unmapped and unused bits read zero
  // ************************************************************
  logic [7:0] pin_levels;
  // pin 1 shows its driven level while this block drives it
  assign pin_levels = {gpio_i[7:1], gpio1_oe_n_o ? gpio_i[0] : gpio1_o};

  always_comb begin
    next_dat = 32'h0000_0000;
    if (hit(gisa_pkg::IDX_GLOBAL_INTERRUPT_SUMMARY)) begin
      next_dat[7:0] = summary;
    end else if (hit(gisa_pkg::IDX_GLOBAL_INTERRUPT_SUMMARY_ENABLE)) begin
      next_dat[7:0] = summary_enable;
    end else if (hit(gisa_pkg::IDX_GLOBAL_LIVE_STATUS)) begin
      next_dat[1:0] = {pll_unlock_live, perf_update_done_live};
    end else if (hit(gisa_pkg::IDX_GLOBAL_LATCHED_STATUS)) begin
      next_dat[4:0] = latched;
    end else if (hit(gisa_pkg::IDX_GLOBAL_STATUS_INTERRUPT_ENABLE)) begin
      next_dat[2:0] = status_enable;
    end else if (hit(gisa_pkg::IDX_GENERAL_PIN_READBACK)) begin
      next_dat[7:0] = pin_levels;
    end else if (hit(gisa_pkg::IDX_GLOBAL_CONTROL)) begin
      next_dat[11:0] = control;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (req && !we_i) begin
      dat_o <= next_dat;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  property p_port_irq;
    @(posedge clk_i) disable iff (rst_i)
      |(port_summary_flags & summary_enable[7:4]) |=> (!int_n_o && !int_oe_n_o);
  endproperty
  a_port_irq: assert property (p_port_irq) else $error("port summary did not pull interrupt low");
  property p_tx_irq;
    @(posedge clk_i) disable iff (rst_i)
      (tx_sysif_summary_flag && summary_enable[1]) |=> (!int_n_o && !int_oe_n_o);
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("tx summary did not pull interrupt low");
  property p_global_irq;
    @(posedge clk_i) disable iff (rst_i)
      (latched[2] && status_enable[2] && summary_enable[0]) |=> !int_n_o;
  endproperty
  a_global_irq: assert property (p_global_irq) else $error("global source did not pull interrupt low");
  property p_idle_mode;
    @(posedge clk_i) disable iff (rst_i)
      !irq_any |=> (int_n_o && (int_oe_n_o == !$past(interrupt_pin_idle_mode)));
  endproperty
  a_idle_mode: assert property (p_idle_mode) else $error("interrupt idle level wrong");
  property p_pin1_low;
    @(posedge clk_i) disable iff (rst_i)
      (pin1_function_select == 2'h2) |=> (!gpio1_oe_n_o && !gpio1_o);
  endproperty
  a_pin1_low: assert property (p_pin1_low) else $error("pin 1 not driven low");
  property p_unlock_latch;
    @(posedge clk_i) disable iff (rst_i)
      !pll_unlock_live ##1 pll_unlock_live |=> latched[1];
  endproperty
  a_unlock_latch: assert property (p_unlock_latch) else $error("unlock rise not latched");
  property p_live_unlock;
    @(posedge clk_i) disable iff (rst_i)
      !(&pll_locked_i) |=> pll_unlock_live;
  endproperty
  a_live_unlock: assert property (p_live_unlock) else $error("live unlock not high");
  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
      (latched[2] && !clr_vec[2]) |=> latched[2];
  endproperty
  a_hold: assert property (p_hold) else $error("latched bit lost without clear");
  property p_clear_read;
    @(posedge clk_i) disable iff (rst_i)
      (clr_vec == 5'h1f && set_vec == 5'h00) |=> (latched == 5'h00);
  endproperty
  a_clear_read: assert property (p_clear_read) else $error("read did not clear latched bits");
  property p_upper_zero;
    @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && !hit(gisa_pkg::IDX_GLOBAL_CONTROL)) |=> (ack_o && dat_o[31:8] == 24'h000000);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("unused upper bits not zero");

  c_irq:     cover property (@(posedge clk_i) disable iff (rst_i) $fell(int_n_o));
  c_cor:     cover property (@(posedge clk_i) disable iff (rst_i) latched != 5'h00 && clr_vec == 5'h1f);
  c_pin1_st: cover property (@(posedge clk_i) disable iff (rst_i) pin1_function_select == 2'h1 && gpio1_o);
  c_perf:    cover property (@(posedge clk_i) disable iff (rst_i) perf_rise);

endmodule

`default_nettype wire

//--- tb/int_line_host.sv
// host side model of the interrupt wire and the pin 1 wire
`timescale 1ns/1ps
`default_nettype none

module int_line_host (
  input  wire logic int_n_i,
  input  wire logic int_oe_n_i,
  input  wire logic pin1_i,
  input  wire logic pin1_oe_n_i,
  input  wire logic pin1_ext_i,   // level the board puts on pin 1
  output logic      int_wire_o,   // interrupt line as the host sees it
  output logic      pin1_wire_o   // pin 1 line as every party sees it
);
  // released interrupt line floats up through the board pull-up
  assign int_wire_o  = int_oe_n_i ? 1'b1 : int_n_i;
  // board only wins while the device leaves pin 1 alone
  assign pin1_wire_o = pin1_oe_n_i ? pin1_ext_i : pin1_i;
endmodule

`default_nettype wire

//--- tb/global_interrupt_status_aggregator_tb_top.sv
// self-checking bench for the global interrupt and status aggregator
`timescale 1ns/1ps
`default_nettype none

module global_interrupt_status_aggregator_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, tick = 1'b0, cref = 1'b0, psa = 1'b0;
  logic [7:0]  adr = 8'h00, gpio_ext = 8'ha5;   // board levels on the pins
  logic [3:0]  sel = 4'h0, port_isr = 4'h0, done = 4'h0, updsel;
  logic [31:0] dat_w = 32'h0, dat_r, q;
  logic [1:0]  txl = 2'h0, txe = 2'h0;
  logic [2:0]  lock = 3'h7;                     // locked at start, so no early unlock event
  logic        gp1, gp1_oe, int_n, int_oe, upd, int_w, pin1_w;
  int          miscompares = 0, check_count = 0;

  // ************************************************************
  // design, wire model and clock
  // ************************************************************
  global_interrupt_status_aggregator u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .port_isr_any_i(port_isr),
    .tx_sysif_latched_i(txl), .tx_sysif_irq_enable_i(txe), .pll_locked_i(lock),
    .port_update_done_i(done), .one_second_tick_i(tick), .clock_ref_input_pin_i(cref),
    .port_status_select_a_i(psa), .gpio_i({gpio_ext[7:1], pin1_w}), .gpio1_o(gp1),
    .gpio1_oe_n_o(gp1_oe), .int_n_o(int_n), .int_oe_n_o(int_oe),
    .global_update_request_o(upd), .port_global_update_select_o(updsel));
  int_line_host u_host (
    .int_n_i(int_n), .int_oe_n_i(int_oe), .pin1_i(gp1), .pin1_oe_n_i(gp1_oe),
    .pin1_ext_i(gpio_ext[0]), .int_wire_o(int_w), .pin1_wire_o(pin1_w));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // classic cycle: hold everything until ack is sampled, then one idle cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("ack wait", 32'h0, 32'h1);
      give_verdict;
    end
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, q, e);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    rc("sum enable", 8'h48, 32'h0);
    rc("status enable", 8'h60, 32'h0);
    rc("control", 8'h80, 32'h0);
    rc("latched", 8'h58, 32'h0);
    chk("int released", int_oe, 1'b1);
  endtask
  task automatic t_pin1;
    logic e;
    for (int c = 0; c < 4; c++) begin
      e = (c == 0) || (c == 3);      // board drives 1, status A is 0
      wr(8'h80, c);
      tk(2);
      chk("pin1 oe_n", gp1_oe, c == 0);
      chk("pin1 wire", pin1_w, e);
      rc("readback", 8'h70, {24'h0, 8'ha4 | e});
    end
    wr(8'h80, 32'h0);
  endtask
  task automatic t_port;
    port_isr <= 4'b0101;
    tk(3);
    rc("port flags", 8'h40, 32'h50);
    chk("int no enable", int_w, 1'b1);
    wr(8'h48, 32'h20);               // enable a port with no status
    tk(2);
    chk("int other port", int_w, 1'b1);
    wr(8'h48, 32'h10);
    tk(2);
    chk("int port", int_w, 1'b0);
    port_isr <= 4'h0;
    wr(8'h48, 32'h0);
  endtask
  task automatic t_tx;
    txl <= 2'b10;
    txe <= 2'b01;
    tk(3);
    rc("tx not enabled", 8'h40, 32'h0);
    txe <= 2'b11;
    tk(3);
    rc("tx flag", 8'h40, 32'h2);
    chk("int tx off", int_w, 1'b1);
    wr(8'h48, 32'h2);
    tk(2);
    chk("int tx", int_w, 1'b0);
    txl <= 2'b00;
    wr(8'h48, 32'h0);
  endtask
  task automatic t_pll;
    lock <= 3'b011;
    tk(3);
    rc("live unlock", 8'h50, 32'h2);
    rc("latched unlock", 8'h58, 32'h2);
    wr(8'h60, 32'h2);
    wr(8'h48, 32'h1);
    tk(2);
    rc("global flag", 8'h40, 32'h1);
    chk("int global", int_w, 1'b0);
    lock <= 3'b111;
    tk(3);
    rc("live relock", 8'h50, 32'h0);
    rc("unlock held", 8'h58, 32'h2);
    wr(8'h60, 32'h1);                // only the update source enabled
    tk(2);
    chk("int source off", int_w, 1'b1);
    wr(8'h58, 32'h2);                // write one to clear
    rc("unlock cleared", 8'h58, 32'h0);
    wr(8'h60, 32'h0);
    wr(8'h48, 32'h0);
  endtask
  task automatic t_upd;
    wr(8'h80, 32'h0308);             // ports 0 and 1, request held high
    done <= 4'b0001;
    tk(3);
    rc("live partial", 8'h50, 32'h0);
    done <= 4'b0011;
    tk(3);
    chk("request pin", upd, 1'b1);
    chk("select pins", updsel, 4'h3);
    rc("live all", 8'h50, 32'h1);
    wr(8'h80, 32'h030c);             // clear on read from now on
    rc("latched update", 8'h58, 32'h1);
    rc("read cleared", 8'h58, 32'h0);
    wr(8'h80, 32'h0);                // request dropped only after done read high
    done <= 4'h0;
  endtask
  task automatic t_misc;
    tick <= 1'b1;
    @(posedge clk_i);
    tick <= 1'b0;
    tk(3);
    rc("one second", 8'h58, 32'h4);
    wr(8'h60, 32'h4);
    wr(8'h48, 32'h1);
    tk(2);
    chk("int one second", int_w, 1'b0);
    wr(8'h48, 32'h0);
    tk(2);
    chk("int summary off", int_w, 1'b1);
    wr(8'h60, 32'h0);
    wr(8'h58, 32'h1f);
    cref <= 1'b1;
    tk(4);
    rc("clock ref", 8'h58, 32'h8);
    wr(8'h58, 32'h1f);
    gpio_ext[3] <= 1'b1;             // reference moves but is not selected
    tk(4);
    rc("8k ignored", 8'h58, 32'h0);
    wr(8'h80, 32'h20);
    gpio_ext[3] <= 1'b0;             // moves again, now selected
    tk(4);
    rc("8k latched", 8'h58, 32'h10);
    wr(8'h80, 32'h10);               // idle line driven high
    tk(2);
    chk("idle oe_n", int_oe, 1'b0);
    chk("idle level", int_n, 1'b1);
    rc("unmapped", 8'h44, 32'h0);
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    tk(8);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_pin1;
    t_port;
    t_tx;
    t_pll;
    t_upd;
    t_misc;
    give_verdict;
  end
  initial begin
    tk(20000);                       // whole run needs well under 2000 cycles
    miscompares++;
    give_verdict;
  end
endmodule

`default_nettype wire
